// *** rtl/frtcc_params.svh ***
// Register offsets, field positions, reset values and counts of the timer
`ifndef FRTCC_PARAMS_SVH
`define FRTCC_PARAMS_SVH

// ----------------------------------------------------------------
// Register word offsets
// ----------------------------------------------------------------
`define FRTCC_A_COUNT   4'h0
`define FRTCC_A_CTRL    4'h1
`define FRTCC_A_CMP0    4'h2
`define FRTCC_A_CMP1    4'h3
`define FRTCC_A_OCTRL   4'h4
`define FRTCC_A_OLEVEL  4'h5
`define FRTCC_A_ICTRL   4'h6
`define FRTCC_A_CAP0    4'h7
`define FRTCC_A_CAP1    4'h8
`define FRTCC_A_STATUS  4'h9
`define FRTCC_A_MASK    4'hA

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FRTCC_CTL_STOP  0
`define FRTCC_CTL_COUNTER_ZERO_REQUEST 1
`define FRTCC_CTL_PSEL  2
`define FRTCC_CTL_MCLR  4
`define FRTCC_OC_EN0    0
`define FRTCC_OC_EN1    1
`define FRTCC_OC_PAIR   2
`define FRTCC_IC_EDGE0  0
`define FRTCC_IC_EDGE1  2
`define FRTCC_IC_DSEL   4
`define FRTCC_ST_OVF    0
`define FRTCC_ST_CMP0   1
`define FRTCC_ST_CMP1   2
`define FRTCC_ST_CAP    3

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define FRTCC_CNT_RST   16'h0000
`define FRTCC_CMP_RST   16'h0000
`define FRTCC_CNT_MAX   16'hFFFF
`define FRTCC_DIV4_M    6'h03
`define FRTCC_DIV16_M   6'h0F
`define FRTCC_DIV32_M   6'h1F
`define FRTCC_DIV64_M   6'h3F

`endif

// *** rtl/frtcc_pkg.sv ***
// Types shared by the free-run timer with capture and compare
package frtcc_pkg;

    // Prescaler selection
    typedef enum logic [1:0] {
        FRTCC_DIV4  = 2'h0,
        FRTCC_DIV16 = 2'h1,
        FRTCC_DIV32 = 2'h2,
        FRTCC_DIV64 = 2'h3
    } frtcc_psel_type;

    // Capture edge selection
    typedef enum logic [1:0] {
        FRTCC_EDGE_OFF  = 2'h0,
        FRTCC_EDGE_RISE = 2'h1,
        FRTCC_EDGE_FALL = 2'h2,
        FRTCC_EDGE_BOTH = 2'h3
    } frtcc_edge_type;

    // Whole state of the main module
    typedef struct packed {
        logic [15:0]    cnt;      // Free-running count
        logic [5:0]     pre;      // Prescaler
        logic           stop;     // Counter halted
        logic           mclr;     // Clear on compare 0 match
        frtcc_psel_type psel;     // Prescale choice
        logic [15:0]    cmp0;     // Compare value 0
        logic [15:0]    cmp1;     // Compare value 1
        logic [1:0]     oc_en;    // Compare toggle enables
        logic           pair;     // Both matches drive pin 0
        logic [1:0]     pin;      // Compare output levels
        frtcc_edge_type edge0;    // Capture 0 edge
        frtcc_edge_type edge1;    // Capture 1 edge
        logic [1:0]     dsel;     // Capture to transfer service
        logic [1:0]     in_prev;  // Last capture input levels
        logic [4:0]     status;   // Sticky event flags
        logic [4:0]     mask;     // Interrupt enables
        logic [15:0]    rdata;    // Read data
        logic           irq;      // Interrupt level
        logic [1:0]     dma_req;  // Transfer request pulses
    } frtcc_state_type;

    // State of the capture store
    typedef struct packed {
        logic [1:0][15:0] word;   // Captured counts
    } frtcc_mem_type;

endpackage

// *** rtl/frtcc_capture_mem.sv ***
// Two-word store holding the captured counter values
`timescale 1ns/1ps
`include "frtcc_params.svh"

module frtcc_capture_mem (
    input  wire logic             clk,     // System clock
    input  wire logic             rst_b,   // Async reset, active low
    input  wire logic [1:0]       we,      // Per-word write enable
    input  wire logic [15:0]      wdata,   // Counter value to store
    output logic      [1:0][15:0] word     // Stored words, from flops
);
    import frtcc_pkg::*;

    frtcc_mem_type s;        // Current state
    frtcc_mem_type next_s;   // Next state

    // ----------------------------------------------------------------
    // Next state: each word loads on its own enable
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        for (int i = 0; i < 2; i++) begin
            if (we[i]) begin
                next_s.word[i] = wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign word = s.word;

endmodule

// *** rtl/frtcc_top.sv ***
// Free-running 16-bit timer with two compare and two capture channels
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "frtcc_params.svh"

module frtcc_top (
    input  wire logic        clk,      // 125 MHz system clock
    input  wire logic        rst_b,    // Async reset, active low
    input  wire logic [3:0]  addr,     // Register word address
    input  wire logic [15:0] wdata,    // Write data
    input  wire logic        wr,       // Write strobe
    input  wire logic        rd,       // Read strobe
    output logic      [15:0] rdata,    // Read data, cycle after rd
    input  wire logic [1:0]  cap_in,   // Capture input pins
    output logic      [1:0]  cmp_out,  // Compare output pins
    output logic             irq,      // Interrupt level
    output logic      [1:0]  dma_req   // Transfer request pulses
);
    import frtcc_pkg::*;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Prescaler tick for the chosen division
    function automatic logic pre_tick(input frtcc_psel_type sel,
                                      input logic [5:0] pre);
        logic [5:0] m;
        m = `FRTCC_DIV64_M;
        unique case (sel)
            FRTCC_DIV4:  m = `FRTCC_DIV4_M;
            FRTCC_DIV16: m = `FRTCC_DIV16_M;
            FRTCC_DIV32: m = `FRTCC_DIV32_M;
            FRTCC_DIV64: m = `FRTCC_DIV64_M;
        endcase
        return (pre & m) == m;
    endfunction

    // Edge match for one capture input
    function automatic logic edge_hit(input frtcc_edge_type mode,
                                      input logic prev,
                                      input logic cur);
        logic r;
        r = 1'b0;
        unique case (mode)
            FRTCC_EDGE_OFF:  r = 1'b0;
            FRTCC_EDGE_RISE: r = !prev && cur;
            FRTCC_EDGE_FALL: r = prev && !cur;
            FRTCC_EDGE_BOTH: r = prev != cur;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    frtcc_state_type  s;         // Current state
    frtcc_state_type  next_s;    // Next state
    logic [1:0]       cap_evt;   // Capture edge seen this cycle
    logic [1:0][15:0] cap_word;  // Captured values
    frtcc_edge_type   edge_sel [2];  // Edge modes by channel

    assign edge_sel[0] = s.edge0;
    assign edge_sel[1] = s.edge1;

    // ----------------------------------------------------------------
    // Capture edge detectors
    // ----------------------------------------------------------------
    // Inputs are taken as synchronous, so the previous sample
    // is the only history needed
    for (genvar g = 0; g < 2; g++) begin : g_cap
        assign cap_evt[g] = edge_hit(edge_sel[g], s.in_prev[g],
                                     cap_in[g]);
    end

    // ----------------------------------------------------------------
    // Capture store
    // ----------------------------------------------------------------
    frtcc_capture_mem u_mem (
        .clk   (clk),
        .rst_b (rst_b),
        .we    (cap_evt),
        .wdata (s.cnt),
        .word  (cap_word)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic       tick;    // Counter advances this cycle
        logic       m0;      // Compare 0 match
        logic       m1;      // Compare 1 match
        logic       ovf;     // Wrap from all ones
        logic [1:0] tog;     // Pin toggles
        logic [4:0] set;     // Flags raised this cycle
        logic       wr_ctl;  // Control write
        tick   = 1'b0;
        m0     = 1'b0;
        m1     = 1'b0;
        ovf    = 1'b0;
        tog    = 2'b00;
        set    = 5'h00;
        wr_ctl = wr && addr == `FRTCC_A_CTRL;
        next_s = s;

        // Prescaler runs freely; a halted counter ignores its ticks
        next_s.pre = s.pre + 6'h01;
        tick = !s.stop && pre_tick(s.psel, s.pre);

        // Matches are judged on the count as it stands before the tick
        m0  = tick && s.cnt == s.cmp0;
        m1  = tick && s.cnt == s.cmp1;
        ovf = tick && s.cnt == `FRTCC_CNT_MAX;

        // Counter: software clear, then load, then count
        if (wr_ctl && wdata[`FRTCC_CTL_COUNTER_ZERO_REQUEST]) begin
            next_s.cnt = `FRTCC_CNT_RST;
            next_s.pre = 6'h00;
        end else if (wr && addr == `FRTCC_A_COUNT) begin
            // Loading while running is allowed; the load wins and a tick in the same cycle is lost
            next_s.cnt = wdata;
        end else if (tick) begin
            if (m0 && s.mclr) begin
                next_s.cnt = `FRTCC_CNT_RST;
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
        end

        // Compare output toggles, optionally paired onto pin 0
        tog[0] = (m0 && s.oc_en[0]) ||
                 (s.pair && m1 && s.oc_en[1]);
        tog[1] = !s.pair && m1 && s.oc_en[1];
        if (wr && addr == `FRTCC_A_OLEVEL) begin
            next_s.pin = wdata[1:0];
        end
        next_s.pin = next_s.pin ^ tog;

        // Input history for edge detection
        next_s.in_prev = cap_in;

        // Capture events go either to flags or to transfer service
        next_s.dma_req = cap_evt & s.dsel;

        // Event flags
        set[`FRTCC_ST_OVF]  = ovf;
        set[`FRTCC_ST_CMP0] = m0;
        set[`FRTCC_ST_CMP1] = m1;
        set[`FRTCC_ST_CAP +: 2] = cap_evt & ~s.dsel;

        // A read clears the flags, but a new event wins
        if (rd && addr == `FRTCC_A_STATUS) begin
            next_s.status = set;
        end else begin
            next_s.status = s.status | set;
        end

        // Register writes
        if (wr) begin
            unique case (addr)
                `FRTCC_A_CTRL: begin
                    next_s.stop = wdata[`FRTCC_CTL_STOP];
                    next_s.psel = frtcc_psel_type'(wdata[`FRTCC_CTL_PSEL +: 2]);
                    next_s.mclr = wdata[`FRTCC_CTL_MCLR];
                end
                `FRTCC_A_CMP0: begin
                    next_s.cmp0 = wdata;
                end
                `FRTCC_A_CMP1: begin
                    next_s.cmp1 = wdata;
                end
                `FRTCC_A_OCTRL: begin
                    next_s.oc_en = wdata[`FRTCC_OC_EN0 +: 2];
                    next_s.pair  = wdata[`FRTCC_OC_PAIR];
                end
                `FRTCC_A_ICTRL: begin
                    next_s.edge0 = frtcc_edge_type'(wdata[`FRTCC_IC_EDGE0 +: 2]);
                    next_s.edge1 = frtcc_edge_type'(wdata[`FRTCC_IC_EDGE1 +: 2]);
                    next_s.dsel  = wdata[`FRTCC_IC_DSEL +: 2];
                end
                `FRTCC_A_MASK: begin
                    next_s.mask = wdata[4:0];
                end
                // Captures and status are read only; count and level writes are taken above, others ignored
                default: begin
                end
            endcase
        end

        // Read data stands for one cycle only
        next_s.rdata = 16'h0000;
        if (rd) begin
            unique case (addr)
                `FRTCC_A_COUNT:  next_s.rdata = s.cnt;
                `FRTCC_A_CTRL:   next_s.rdata = {11'h000, s.mclr, s.psel,
                                                 1'b0, s.stop};
                `FRTCC_A_CMP0:   next_s.rdata = s.cmp0;
                `FRTCC_A_CMP1:   next_s.rdata = s.cmp1;
                `FRTCC_A_OCTRL:  next_s.rdata = {13'h0000, s.pair, s.oc_en};
                `FRTCC_A_OLEVEL: next_s.rdata = {14'h0000, s.pin};
                `FRTCC_A_ICTRL:  next_s.rdata = {10'h000, s.dsel,
                                                 s.edge1, s.edge0};
                `FRTCC_A_CAP0:   next_s.rdata = cap_word[0];
                `FRTCC_A_CAP1:   next_s.rdata = cap_word[1];
                `FRTCC_A_STATUS: next_s.rdata = {11'h000, s.status};
                `FRTCC_A_MASK:   next_s.rdata = {11'h000, s.mask};
                // Unmapped addresses read as zero
                default:         next_s.rdata = 16'h0000;
            endcase
        end

        // Interrupt follows the flags it will hold next
        next_s.irq = |(next_s.status & next_s.mask);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Whole state resets to zero: counter runs at clk/4 from reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, straight from flops
    // ----------------------------------------------------------------
    assign rdata   = s.rdata;
    assign cmp_out = s.pin;
    assign irq     = s.irq;
    assign dma_req = s.dma_req;

endmodule

// *** testbench/frtcc_props.sv ***
// Concurrent checks on the timer's register port and pins
`timescale 1ns/1ps
`include "frtcc_params.svh"

module frtcc_props (
    input wire logic        clk,      // Clock
    input wire logic        rst_b,    // Reset, active low
    input wire logic [3:0]  addr,     // Word address
    input wire logic [15:0] wdata,    // Write data
    input wire logic        wr,       // Write strobe
    input wire logic        rd,       // Read strobe
    input wire logic [15:0] rdata,    // Read data
    input wire logic [1:0]  cap_in,   // Capture pins
    input wire logic [1:0]  cmp_out,  // Compare pins
    input wire logic        irq,      // Interrupt level
    input wire logic [1:0]  dma_req   // Transfer requests
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [1:0] up;    // Cycles since reset, saturating
    logic       drop;  // Strobe that may lower the interrupt
    assign drop = (rd && addr == `FRTCC_A_STATUS) || (wr && addr == `FRTCC_A_MASK);

    // History checks look two cycles back, so wait until that is clean
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up <= 2'h0;
        end else if (up != 2'h3) begin
            up <= up + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Register port
    // ----------------------------------------------------------------
    sequence cmp0_write;
        wr && addr == `FRTCC_A_CMP0;
    endsequence
    sequence cmp0_read;
        rd && addr == `FRTCC_A_CMP0;
    endsequence

    idle_rdata_a: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    unmapped_read_a: assert property (
        rd && addr > `FRTCC_A_MASK |=> rdata == 16'h0000)
        else $error("unmapped read gave data");
    clear_bit_zero_a: assert property (
        rd && addr == `FRTCC_A_CTRL |=> !rdata[`FRTCC_CTL_COUNTER_ZERO_REQUEST])
        else $error("clear bit read back as one");
    cmp_readback_a: assert property (
        cmp0_write ##1 !wr ##1 cmp0_read |=> rdata == $past(wdata, 3))
        else $error("compare 0 read back a different value");

    // ----------------------------------------------------------------
    // Interrupt and pins
    // ----------------------------------------------------------------
    mask_off_a: assert property (
        wr && addr == `FRTCC_A_MASK && wdata == 16'h0000 |-> ##2 !irq)
        else $error("interrupt high with all enables off");
    irq_fall_a: assert property ($fell(irq) |-> $past(drop) || $past(drop, 2))
        else $error("interrupt fell without a status read or mask write");
    pin_hold_a: assert property (
        $changed(cmp_out) && !$past(wr) && up == 2'h3
        |=> ($stable(cmp_out) || $past(wr))[*3])
        else $error("compare pins toggled faster than the tick rate");
    dma_cause_a: assert property (
        dma_req != 2'h0 && up == 2'h3
        |-> (dma_req & ~($past(cap_in) ^ $past(cap_in, 2))) == 2'h0)
        else $error("transfer request without an input edge");
endmodule

bind frtcc_top frtcc_props u_props (
    .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cap_in(cap_in), .cmp_out(cmp_out), .irq(irq), .dma_req(dma_req)
);

// *** testbench/frtcc_pins_model.sv ***
// Pin-side model: the external sources feeding the capture inputs
`timescale 1ns/1ps

module frtcc_pins_model (
    input  wire logic       clk,     // Clock
    input  wire logic       rst_b,   // Reset, active low
    input  wire logic [1:0] want,    // Levels the bench asks for
    output logic      [1:0] cap_in   // Capture pins to the timer
);
    // Sources change just after an edge and hold a whole cycle at least,
    // so every level is seen by the timer's synchronous edge detector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cap_in <= 2'h0;
        end else begin
            cap_in <= want;
        end
    end
endmodule

// *** testbench/free_run_timer_capture_compare_test.sv ***
// Self-checking bench for the timer through its register port and pins
`timescale 1ns/1ps
`include "frtcc_params.svh"

module free_run_timer_capture_compare_test;
    import frtcc_pkg::*;

    logic        clk;        // Clock
    logic        rst_b;      // Reset, active low
    logic [3:0]  addr;       // Word address
    logic [15:0] wdata;      // Write data
    logic        wr;         // Write strobe
    logic        rd;         // Read strobe
    logic [15:0] rdata;      // Read data
    logic [1:0]  want;       // Levels asked of the pin model
    logic [1:0]  cap_in;     // Capture pins
    logic [1:0]  cmp_out;    // Compare pins
    logic        irq;        // Interrupt
    logic [1:0]  dma_req;    // Transfer requests
    logic [15:0] v;          // Last read value
    logic [15:0] a0;         // Expected or earlier value
    int          err_total;  // Mismatches
    int          tests_run;  // Comparisons
    int          dma0;       // Transfer pulses on channel 0

    frtcc_top DUT (
        .clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cap_in(cap_in), .cmp_out(cmp_out), .irq(irq), .dma_req(dma_req)
    );
    frtcc_pins_model pins (.clk(clk), .rst_b(rst_b), .want(want), .cap_in(cap_in));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Pulses last one cycle, so each covers exactly one falling edge
    always @(negedge clk) begin
        if (dma_req[0] === 1'b1) begin
            dma0 <= dma0 + 1;
        end
    end

    // ----------------------------------------------------------------
    // Bus access and comparison
    // ----------------------------------------------------------------
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        @(posedge clk);
    endtask

    // Data is taken mid-cycle while the answer stands, never at a launch edge
    task automatic rd_reg(input logic [3:0] a);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        v = rdata;
        @(posedge clk);
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Pin levels as {irq, cmp_out}, looked at mid-cycle once settled
    task automatic chk_pin(input string what, input logic [2:0] exp);
        @(negedge clk);
        chk(what, {13'h0000, exp}, {13'h0000, irq, cmp_out});
        @(posedge clk);
    endtask

    task automatic rc(input logic [3:0] a, input logic [15:0] exp, input string what);
        rd_reg(a);
        chk(what, exp, v);
    endtask

    // Bounded wait for a pin or the interrupt to move; sampled mid-cycle,
    // returns on the rising edge after the change
    task automatic wait_chg(input logic [2:0] old);
        int n;
        n = 0;
        @(negedge clk);
        while ({irq, cmp_out} === old && n < 300) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
    endtask

    task automatic drive(input logic [1:0] lv);
        want <= lv;
        repeat (4) @(posedge clk);
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Watchdog: the tests need well under 20 us
    initial begin
        #100us;
        err_total++;
        test_done;
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        want = 2'h0;
        err_total = 0;
        tests_run = 0;
        dma0 = 0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // Status must be read before the first tick can flag a match at zero
        rc(`FRTCC_A_STATUS, 16'h0000, "status at reset");
        for (int i = 1; i < 16; i++) begin
            if (i != 9) begin
                rc(4'(i), 16'h0000, "reset value");
            end
        end
        chk_pin("pins at reset", 3'h0);
        $display("reset values done");

        wr_reg(`FRTCC_A_CTRL, 16'h0001);
        wr_reg(`FRTCC_A_COUNT, 16'h1234);
        repeat (70) @(posedge clk);
        rc(`FRTCC_A_COUNT, 16'h1234, "stopped count");
        wr_reg(`FRTCC_A_CTRL, 16'h0003);
        rc(`FRTCC_A_COUNT, 16'h0000, "software clear");
        $display("stop, load and clear done");

        // A periodic tick advances the count by four over four periods
        for (int p = 0; p < 4; p++) begin
            wr_reg(`FRTCC_A_CTRL, 16'(p * 4));
            rd_reg(`FRTCC_A_COUNT);
            a0 = v;
            repeat (4 * (p == 0 ? 4 : 8 << p) - 2) @(posedge clk);
            rd_reg(`FRTCC_A_COUNT);
            chk("count advance", 16'h0004, v - a0);
        end
        $display("prescaler done");

        // Compare values parked far away so no match flag disturbs
        wr_reg(`FRTCC_A_CMP0, 16'h8000);
        wr_reg(`FRTCC_A_CMP1, 16'h8000);
        wr_reg(`FRTCC_A_CTRL, 16'h0001);
        wr_reg(`FRTCC_A_COUNT, 16'hFFFE);
        rd_reg(`FRTCC_A_STATUS);
        wr_reg(`FRTCC_A_MASK, 16'h0001);
        wr_reg(`FRTCC_A_CTRL, 16'h0000);
        wait_chg(3'h0);
        rc(`FRTCC_A_COUNT, 16'h0000, "count after wrap");
        rc(`FRTCC_A_STATUS, 16'h0001, "overflow flag");
        rc(`FRTCC_A_STATUS, 16'h0000, "status after read");
        chk_pin("irq after clear", 3'h0);
        $display("overflow done");

        wr_reg(`FRTCC_A_CTRL, 16'h0001);
        wr_reg(`FRTCC_A_COUNT, 16'h0000);
        wr_reg(`FRTCC_A_CMP0, 16'h0008);
        rc(`FRTCC_A_CMP0, 16'h0008, "compare 0");
        wr_reg(`FRTCC_A_CMP1, 16'h0010);
        wr_reg(`FRTCC_A_OCTRL, 16'h0003);
        wr_reg(`FRTCC_A_OLEVEL, 16'h0002);
        rc(`FRTCC_A_OLEVEL, 16'h0002, "preset level");
        chk_pin("preset pins", 3'b010);
        rd_reg(`FRTCC_A_STATUS);
        wr_reg(`FRTCC_A_MASK, 16'h0004);
        wr_reg(`FRTCC_A_CTRL, 16'h0000);
        wait_chg(3'b010);
        rc(`FRTCC_A_COUNT, 16'h0009, "count at match 0");
        chk_pin("pin 0 toggled", 3'b011);
        wait_chg(3'b011);
        @(posedge clk);
        chk_pin("pin 1 toggled", 3'b101);
        rc(`FRTCC_A_STATUS, 16'h0006, "match flags");
        $display("compare done");

        wr_reg(`FRTCC_A_CTRL, 16'h0001);
        wr_reg(`FRTCC_A_COUNT, 16'h0000);
        wr_reg(`FRTCC_A_CTRL, 16'h0010);
        repeat (100) @(posedge clk);
        rd_reg(`FRTCC_A_COUNT);
        chk("count held under compare 0", 16'h0001, {15'h0000, v <= 16'h0008});
        $display("clear on match done");

        wr_reg(`FRTCC_A_CTRL, 16'h0001);
        wr_reg(`FRTCC_A_COUNT, 16'h0000);
        wr_reg(`FRTCC_A_OCTRL, 16'h0006);
        wr_reg(`FRTCC_A_OLEVEL, 16'h0000);
        wr_reg(`FRTCC_A_MASK, 16'h0000);
        wr_reg(`FRTCC_A_CTRL, 16'h0000);
        wait_chg(3'h0);
        rc(`FRTCC_A_COUNT, 16'h0011, "paired toggle count");
        chk_pin("paired pin", 3'b001);
        $display("pairing done");

        // Stopped counter gives a known value to capture
        wr_reg(`FRTCC_A_CTRL, 16'h0001);
        rd_reg(`FRTCC_A_STATUS);
        rd_reg(`FRTCC_A_CAP0);
        a0 = v;
        for (int e = 1; e < 4; e++) begin
            wr_reg(`FRTCC_A_ICTRL, 16'(e));
            wr_reg(`FRTCC_A_COUNT, 16'h0100 + 16'(e));
            drive(2'b01);
            a0 = e[0] ? 16'h0100 + 16'(e) : a0;
            rc(`FRTCC_A_CAP0, a0, "capture on rise");
            wr_reg(`FRTCC_A_COUNT, 16'h0200 + 16'(e));
            drive(2'b00);
            a0 = e[1] ? 16'h0200 + 16'(e) : a0;
            rc(`FRTCC_A_CAP0, a0, "capture on fall");
        end
        wr_reg(`FRTCC_A_ICTRL, 16'h0008);
        wr_reg(`FRTCC_A_COUNT, 16'h0300);
        drive(2'b10);
        wr_reg(`FRTCC_A_COUNT, 16'h0301);
        drive(2'b00);
        rc(`FRTCC_A_CAP1, 16'h0301, "capture 1");
        rc(`FRTCC_A_CAP0, a0, "capture 0 untouched");
        wr_reg(`FRTCC_A_MASK, 16'h0008);
        @(posedge clk);
        chk_pin("capture irq", 3'b101);
        rc(`FRTCC_A_STATUS, 16'h0018, "capture flags");
        wr_reg(`FRTCC_A_ICTRL, 16'h0011);
        drive(2'b01);
        chk("transfer pulses", 16'h0001, dma0[15:0]);
        rc(`FRTCC_A_STATUS, 16'h0000, "no flag when routed");
        $display("capture done");
        test_done;
    end
endmodule
